// ---- inc/lpddr_init_pkg.sv ----
`default_nettype none
package lpddr_init_pkg;
  // ****************************************************************
  // clock and time
  // ****************************************************************
  localparam int PCLK_MHZ        = 25;
  localparam int T_INIT5_US      = 10;
  localparam int T_ZQINIT_US     = 1;
  // longest time rounds down, least time rounds up
  localparam int INIT5_CYCLES    = (T_INIT5_US * PCLK_MHZ);
  localparam int ZQINIT_CYCLES   = (T_ZQINIT_US * PCLK_MHZ + 0);
  localparam logic [7:0] AINIT_RESET = 8'hc8;
  localparam logic [7:0] AINIT_MAX   = 8'(INIT5_CYCLES - 4);
  localparam logic [7:0] PERIOD_TOL  = 8'h01;
  // ****************************************************************
  // pins and data
  // ****************************************************************
  localparam int CA_W    = 10;
  localparam int DQ_W    = 16;
  localparam int BEATS   = 4;
  localparam int WORD_W  = DQ_W * BEATS;
  localparam int WADDR_W = 4;
  // ****************************************************************
  // command encodings, first half on rising ck edge, ca[3:0] for MRW/MRR, ca[2:0] for write/read
  // ****************************************************************
  localparam logic [3:0] CMD_MRW     = 4'h0;
  localparam logic [3:0] CMD_MRR     = 4'h8;
  localparam logic [2:0] CMD_WRITE   = 3'h4;
  localparam logic [2:0] CMD_READ    = 3'h5;
  localparam logic [7:0] MA_MR0      = 8'h00;
  localparam logic [7:0] MA_MR1      = 8'h01;
  localparam logic [7:0] MA_MR2      = 8'h02;
  localparam logic [7:0] MA_MR3      = 8'h03;
  localparam logic [7:0] MA_MR8      = 8'h08;
  localparam logic [7:0] MA_ZQ       = 8'h0a;
  localparam logic [7:0] MA_RESET    = 8'h3f;
  localparam logic [7:0] OP_ZQ_INIT  = 8'hff;
  // arbitrary neutral value
  localparam logic [7:0] MR8_VALUE   = 8'h00;
  // ****************************************************************
  // mode register 0 fields
  // ****************************************************************
  localparam int MR0_DAI   = 0;
  localparam int MR0_RZQ_L = 3;
  localparam logic [1:0] RZQ_OK   = 2'h3;
  localparam logic [1:0] RZQ_OPEN = 2'h1;
  // ****************************************************************
  // apb register map
  // ****************************************************************
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_AINIT  = 8'h04;
  localparam logic [7:0] A_STATUS = 8'h08;
  localparam logic [7:0] A_MR0    = 8'h0c;
  localparam logic [7:0] A_MRCFG  = 8'h10;
  localparam int CTRL_RZQ   = 0;
  localparam int ST_FERR    = 8;
  typedef enum logic [2:0] {
    ST_POWER, ST_NOP_IDLE, ST_AUTO_INIT, ST_IDLE, ST_ZQ
  } init_state_e;
endpackage : lpddr_init_pkg
`default_nettype wire

// ---- design/mode_word_ram.sv ----
`default_nettype none
module mode_word_ram
  import lpddr_init_pkg::*;
(
  input  wire logic               pclk,
  input  wire logic               we,
  input  wire logic [WADDR_W-1:0] waddr,
  input  wire logic [WORD_W-1:0]  wdata,
  input  wire logic [WADDR_W-1:0] raddr,
  output logic      [WORD_W-1:0]  rdata
);
  logic [WORD_W-1:0] mem [0:(1<<WADDR_W)-1];

  always_ff @(posedge pclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule : mode_word_ram
`default_nettype wire

// ---- design/lpddr_init_sequence.sv ----
`default_nettype none
// Operation
// - auto-init finishes within 10 us of reset; controller waits or polls
// - register 0 flag reads zero when auto-init done, device then idle
// - calibration write to register 10 calibrates, updates register 0
// - after init clock rate changes only via clock-stop procedure
// - lowest column bit never sent; device takes it as zero
// - device ignores unused row and column address bits
// - each access moves one 4n word as four n-bit half-cycle beats
module lpddr_init_sequence
  import lpddr_init_pkg::*;
(
  input  wire logic            pclk,
  input  wire logic            presetn,
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [7:0]      paddr,
  input  wire logic [31:0]     pwdata,
  output logic      [31:0]     prdata,
  output logic                 pready,
  output logic                 pslverr,
  input  wire logic            ck,
  input  wire logic            cke,
  input  wire logic            cs_n,
  input  wire logic [CA_W-1:0] ca,
  input  wire logic [DQ_W-1:0] dq_in,
  output logic      [DQ_W-1:0] dq_out,
  output logic                 dq_oe,
  output logic      [7:0]      mrr_data,
  output logic                 mrr_valid
);
  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  localparam int SW = 3 + CA_W + DQ_W;
  logic [SW-1:0] sync1;
  logic [SW-1:0] sync2;
  logic          ck_d;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= '0;
      sync2 <= '0;
      ck_d  <= 1'b0;
    end else begin
      sync1 <= {ck, cke, cs_n, ca, dq_in};
      sync2 <= sync1;
      ck_d  <= sync2[SW-1];
    end
  end

  wire            ck_s    = sync2[SW-1];
  wire            cke_s   = sync2[SW-2];
  wire            csn_s   = sync2[SW-3];
  wire [CA_W-1:0] ca_s    = sync2[DQ_W +: CA_W];
  wire [DQ_W-1:0] dq_s    = sync2[DQ_W-1:0];
  wire            ck_rise = ck_s & ~ck_d;
  wire            ck_fall = ~ck_s & ck_d;
  wire            ck_edge = ck_rise | ck_fall;

  // ****************************************************************
  // command capture over both ck edges
  // ****************************************************************
  logic            cmd_armed;
  logic [CA_W-1:0] ca_rise;
  init_state_e     state;
  init_state_e     next_state;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_armed <= 1'b0;
      ca_rise   <= '0;
    end else if (ck_rise) begin
      cmd_armed <= cke_s & ~csn_s;
      ca_rise   <= ca_s;
    end else if (ck_fall) begin
      cmd_armed <= 1'b0;
    end
  end

  wire       cmd_valid = ck_fall & cmd_armed;
  wire [7:0] ma        = {ca_s[1:0], ca_rise[9:4]};
  wire [7:0] op        = ca_s[9:2];
  wire       is_mrw    = cmd_valid & (ca_rise[3:0] == CMD_MRW);
  wire       is_mrr    = cmd_valid & (ca_rise[3:0] == CMD_MRR);
  wire       is_wr     = cmd_valid & (ca_rise[2:0] == CMD_WRITE);
  wire       is_rd     = cmd_valid & (ca_rise[2:0] == CMD_READ);
  wire       cmd_reset = is_mrw & (ma == MA_RESET);
  wire       cmd_zq    = is_mrw & (ma == MA_ZQ) & (op == OP_ZQ_INIT);
  wire       ready_st  = (state == ST_IDLE);
  // column bit 0 is implied zero, upper row/column bits ignored
  wire [8:0] col       = {ca_s[8:1], 1'b0};
  wire [WADDR_W-1:0] word_addr = col[WADDR_W+1:2];

  // ****************************************************************
  // apb registers
  // ****************************************************************
  logic [31:0] ctrl;
  logic [7:0]  ainit;
  logic        freq_err;
  logic [7:0]  mr0;
  logic [7:0]  mr1;
  logic [7:0]  mr2;
  logic [7:0]  mr3;

  wire setup    = psel & ~penable;
  wire wr_acc   = psel & penable & pwrite;
  wire sel_ctrl = (paddr == A_CTRL);
  wire sel_ain  = (paddr == A_AINIT);
  wire sel_st   = (paddr == A_STATUS);
  wire sel_mr0  = (paddr == A_MR0);
  wire sel_mrc  = (paddr == A_MRCFG);
  wire mapped   = sel_ctrl | sel_ain | sel_st | sel_mr0 | sel_mrc;
  wire [31:0] status_word = {23'h0, freq_err, 5'h0, state};
  wire [31:0] rd_mux = sel_ctrl ? ctrl :
                       sel_ain  ? {24'h0, ainit} :
                       sel_st   ? status_word :
                       sel_mr0  ? {24'h0, mr0} :
                       sel_mrc  ? {8'h0, mr3, mr2, mr1} : 32'h0;
  // clamp so auto-init can never outlast the limit
  wire [7:0] ainit_wr = (pwdata[7:0] > AINIT_MAX) ? AINIT_MAX : pwdata[7:0];

  assign pready = 1'b1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata  <= pwrite ? 32'h0 : rd_mux;
      pslverr <= ~mapped;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl  <= 32'h0;
      ainit <= AINIT_RESET;
    end else if (wr_acc & sel_ctrl) begin
      ctrl  <= {31'h0, pwdata[CTRL_RZQ]};
    end else if (wr_acc & sel_ain) begin
      ainit <= ainit_wr;
    end
  end

  // ****************************************************************
  // initialisation state machine
  // ****************************************************************
  logic [7:0] timer;
  wire        timer_done = (timer == 8'h0);

  always_comb begin
    next_state = state;
    case (state)
      ST_POWER: begin
        if (cke_s) begin
          next_state = ST_NOP_IDLE;
        end
      end
      ST_NOP_IDLE: begin
        next_state = ST_NOP_IDLE;
      end
      ST_AUTO_INIT: begin
        if (timer_done) begin
          next_state = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (cmd_zq) begin
          next_state = ST_ZQ;
        end
      end
      ST_ZQ: begin
        if (timer_done) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_POWER;
      end
    endcase
    // reset write restarts init from any state
    if (cmd_reset) begin
      next_state = ST_AUTO_INIT;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_POWER;
      timer <= 8'h0;
    end else begin
      state <= next_state;
      if (cmd_reset) begin
        timer <= ainit;
      end else if (cmd_zq & ready_st) begin
        timer <= 8'(ZQINIT_CYCLES);
      end else if (!timer_done) begin
        timer <= timer - 8'h1;
      end
    end
  end

  // ****************************************************************
  // mode registers
  // ****************************************************************
  wire mr0_busy = (state == ST_AUTO_INIT);
  wire [1:0] rzq_val = ctrl[CTRL_RZQ] ? RZQ_OK : RZQ_OPEN;
  wire zq_end = (state == ST_ZQ) & timer_done;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mr0 <= 8'h1;
      mr1 <= 8'h0;
      mr2 <= 8'h0;
      mr3 <= 8'h0;
    end else begin
      mr0[MR0_DAI] <= mr0_busy | (state == ST_POWER) | (state == ST_NOP_IDLE);
      if (cmd_reset) begin
        mr0[MR0_RZQ_L +: 2] <= 2'h0;
      end else if (zq_end) begin
        mr0[MR0_RZQ_L +: 2] <= rzq_val;
      end
      if (is_mrw & ready_st & (ma == MA_MR1)) begin
        mr1 <= op;
      end
      if (is_mrw & ready_st & (ma == MA_MR2)) begin
        mr2 <= op;
      end
      if (is_mrw & ready_st & (ma == MA_MR3)) begin
        mr3 <= op;
      end
    end
  end

  wire [7:0] mrr_mux = (ma == MA_MR0) ? mr0 :
                       (ma == MA_MR8) ? MR8_VALUE : 8'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mrr_data  <= 8'h0;
      mrr_valid <= 1'b0;
    end else begin
      mrr_valid <= is_mrr;
      if (is_mrr) begin
        mrr_data <= mrr_mux;
      end
    end
  end

  // ****************************************************************
  // clock rate watch from auto-init onwards
  // ****************************************************************
  logic [7:0] per_cnt;
  logic [7:0] per_last;
  logic       per_known;
  wire [7:0]  per_diff = (per_cnt > per_last) ? per_cnt - per_last : per_last - per_cnt;
  wire        per_sat  = (per_cnt == 8'hff);
  wire        per_bad  = ck_rise & per_known & (per_diff > PERIOD_TOL) & cke_s
                         & (state != ST_POWER) & (state != ST_NOP_IDLE);
  wire        ferr_clr = wr_acc & sel_st & pwdata[ST_FERR];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      per_cnt   <= 8'h0;
      per_last  <= 8'h0;
      per_known <= 1'b0;
      freq_err  <= 1'b0;
    end else begin
      if (ck_rise) begin
        per_cnt   <= 8'h1;
        per_last  <= per_cnt;
        per_known <= ~per_sat & cke_s;
      end else if (!per_sat) begin
        per_cnt <= per_cnt + 8'h1;
      end
      // cke low ends the watch, a stopped clock is flagged at its first rise back; set wins over clear
      if (per_bad) begin
        freq_err <= 1'b1;
      end else if (ferr_clr) begin
        freq_err <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // prefetch data path, four beats per core word
  // ****************************************************************
  logic [1:0]         beat;
  logic               wr_burst;
  logic               rd_burst;
  logic               rd_load;
  logic [WORD_W-1:0]  wr_word;
  logic [WADDR_W-1:0] addr_q;
  logic [WORD_W-1:0]  rd_word;
  logic               ram_we;
  wire  [WORD_W-1:0]  ram_rdata;
  wire                last_beat = (beat == 2'(BEATS - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      beat     <= 2'h0;
      wr_burst <= 1'b0;
      rd_burst <= 1'b0;
      rd_load  <= 1'b0;
      wr_word  <= '0;
      addr_q   <= '0;
      rd_word  <= '0;
      ram_we   <= 1'b0;
      dq_out   <= '0;
      dq_oe    <= 1'b0;
    end else begin
      ram_we  <= 1'b0;
      rd_load <= 1'b0;
      if ((is_wr | is_rd) & ready_st) begin
        addr_q   <= word_addr;
        wr_burst <= is_wr;
        rd_burst <= 1'b0;
        rd_load  <= is_rd;
        beat     <= 2'h0;
      end else if (rd_load) begin
        rd_word  <= ram_rdata;
        rd_burst <= 1'b1;
      end else if (ck_edge & wr_burst) begin
        wr_word  <= {dq_s, wr_word[WORD_W-1:DQ_W]};
        beat     <= beat + 2'h1;
        wr_burst <= ~last_beat;
        ram_we   <= last_beat;
      end else if (ck_edge & rd_burst) begin
        dq_out   <= rd_word[DQ_W-1:0];
        dq_oe    <= 1'b1;
        rd_word  <= {{DQ_W{1'b0}}, rd_word[WORD_W-1:DQ_W]};
        beat     <= beat + 2'h1;
        rd_burst <= ~last_beat;
      end else if (ck_edge) begin
        dq_oe    <= 1'b0;
      end
    end
  end

  mode_word_ram u_ram (
    .pclk  (pclk),
    .we    (ram_we),
    .waddr (addr_q),
    .wdata (wr_word),
    .raddr (word_addr),
    .rdata (ram_rdata)
  );
endmodule : lpddr_init_sequence
`default_nettype wire

// ---- tb/lpddr_init_sequence_assertions.sv ----
`default_nettype none
module lpddr_init_sequence_checker
  import lpddr_init_pkg::*;
(
  input wire logic            pclk,
  input wire logic            presetn,
  input wire logic            psel,
  input wire logic            penable,
  input wire logic            pwrite,
  input wire logic [7:0]      paddr,
  input wire logic [31:0]     pwdata,
  input wire logic [31:0]     prdata,
  input wire logic            pready,
  input wire logic            pslverr,
  input wire logic            ck,
  input wire logic            cke,
  input wire logic            cs_n,
  input wire logic [CA_W-1:0] ca,
  input wire logic [DQ_W-1:0] dq_in,
  input wire logic [DQ_W-1:0] dq_out,
  input wire logic            dq_oe,
  input wire logic [7:0]      mrr_data,
  input wire logic            mrr_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  // ******
  // checks
  // ******
  logic      [4:0] oe_len;
  logic      [3:0] since_cs;
  wire logic [4:0] next_oe_len   = dq_oe ? oe_len + 5'h1 : 5'h0;
  wire logic       cs_sat        = (since_cs == 4'hf);
  wire logic [3:0] next_since_cs = !cs_n ? 4'h0 : (cs_sat ? 4'hf : since_cs + 4'h1);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oe_len   <= 5'h0;
      since_cs <= 4'hf;
    end else begin
      oe_len   <= next_oe_len;
      since_cs <= next_since_cs;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_high: assert property (pready)
    else $error("pready low");
  a_unmapped_err: assert property (psel && penable && paddr > 8'h10 |-> pslverr)
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (psel && penable && paddr <= 8'h10 && paddr[1:0] == 2'h0
                                |-> !pslverr)
    else $error("mapped access refused");
  a_unmapped_zero: assert property (psel && penable && !pwrite && paddr > 8'h10
                                    |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_prdata_hold: assert property (psel && penable |=> $stable(prdata))
    else $error("read data moved in access phase");
  a_mrr_pulse: assert property (mrr_valid |=> !mrr_valid)
    else $error("read result pulse too long");
  a_mrr_hold: assert property ($changed(mrr_data) |-> mrr_valid)
    else $error("read result changed alone");
  a_mrr_cause: assert property (mrr_valid |-> since_cs < 4'h8)
    else $error("read result without command");
  a_oe_min: assert property ($rose(dq_oe) |-> dq_oe [*8])
    else $error("read burst cut short");
  a_oe_max: assert property (dq_oe |-> oe_len < 5'h15)
    else $error("read burst too long");
endmodule : lpddr_init_sequence_checker
bind lpddr_init_sequence lpddr_init_sequence_checker u_lpddr_init_sequence_checker (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
  .pslverr, .ck, .cke, .cs_n, .ca, .dq_in, .dq_out, .dq_oe, .mrr_data, .mrr_valid
);
`default_nettype wire

// ---- tb/lpddr_ctrl_model.sv ----
`default_nettype none
module lpddr_ctrl_model
  import lpddr_init_pkg::*;
(
  output logic            ck,
  output logic            cke,
  output logic            cs_n,
  output logic [CA_W-1:0] ca,
  output logic [DQ_W-1:0] dq_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // **********
  // controller
  // **********
  localparam int TCK    = 320;
  localparam int NOP_CK = (200000 + TCK - 1) / TCK;
  localparam int US_CK  = (1000 + TCK - 1) / TCK;
  int hp = TCK / 2;
  bit run = 1'b0;
  initial begin
    ck = 1'b0;
    cke = 1'b0;
    cs_n = 1'b1;
    ca = '0;
    dq_in = '0;
    #7;
    forever begin
      #(hp);
      if (run) ck = ~ck;
    end
  end
  task automatic idle(input int n);
    repeat (n) @(posedge ck);
  endtask : idle
  task automatic power_up;
    #100;
    run = 1'b1;
    repeat (6) @(posedge ck);
    #80;
    cke = 1'b1;
  endtask : power_up
  // halves centred on the edges, then four data beats
  task automatic cmd(input logic [9:0] r, input logic [9:0] f, input logic [63:0] w);
    @(negedge ck);
    #80;
    cs_n = 1'b0;
    ca = r;
    @(posedge ck);
    #80;
    ca = f;
    @(negedge ck);
    #80;
    cs_n = 1'b1;
    ca = ~f;
    for (int i = 0; i < 4; i++) begin
      dq_in = w[16*i +: 16];
      @(ck);
      #80;
    end
    dq_in = ~w[63:48];
  endtask : cmd
  task automatic mrw(input logic [7:0] ma, input logic [7:0] op);
    cmd({ma[5:0], 4'h0}, {op, ma[7:6]}, '1);
  endtask : mrw
  task automatic mrr(input logic [7:0] ma);
    cmd({ma[5:0], 4'h8}, {8'h00, ma[7:6]}, '1);
  endtask : mrr
endmodule : lpddr_ctrl_model
`default_nettype wire

// ---- tb/lpddr_init_sequence_tb.sv ----
`default_nettype none
module lpddr_init_sequence_tb
  import lpddr_init_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic            pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]      paddr, mrr_data, mrr_cap, v;
  logic [31:0]     pwdata, prdata, q;
  logic            ck, cke, cs_n, dq_oe, mrr_valid, e;
  logic [CA_W-1:0] ca;
  logic [DQ_W-1:0] dq_in, dq_out;
  logic [15:0]     rd_q[$];
  int              err_count, tests_run, seed;
  bit              mrr_seen;
  localparam logic [7:0]  RA [5] = '{A_CTRL, A_AINIT, A_STATUS, A_MR0, A_MRCFG};
  localparam logic [31:0] RV [5] = '{32'h0, 32'hc8, 32'h0, 32'h1, 32'h0};
  lpddr_init_sequence u_lpddr_init_sequence (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .ck, .cke, .cs_n, .ca, .dq_in, .dq_out, .dq_oe, .mrr_data, .mrr_valid
  );
  lpddr_ctrl_model u_lpddr_ctrl_model (.ck, .cke, .cs_n, .ca, .dq_in);
  // *****
  // bench
  // *****
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (mrr_valid === 1'b1) begin
      mrr_seen <= 1'b1;
      mrr_cap  <= mrr_data;
    end
    if (dq_oe === 1'b1 && (rd_q.size() == 0 || dq_out !== rd_q[$])) rd_q.push_back(dq_out);
  end
  // watchdog: a stalled link clock still reaches the verdict
  initial begin
    repeat (90000) @(posedge pclk);
    fail();
  end
  function automatic logic [31:0] exp_ainit(input logic [31:0] d);
    return (d[7:0] > AINIT_MAX) ? 32'(AINIT_MAX) : 32'(d[7:0]);
  endfunction : exp_ainit
  task automatic results;
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic fail;
    err_count++;
    results();
  endtask : fail
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 16) fail();
  endtask : apb
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask : rdchk
  task automatic mrr(input logic [7:0] ma);
    mrr_seen = 1'b0;
    u_lpddr_ctrl_model.mrr(ma);
    for (int i = 0; i < 40 && !mrr_seen; i++) @(posedge pclk);
    if (!mrr_seen) fail();
    v = mrr_cap;
  endtask : mrr
  task automatic wait_dai(input time t0);
    u_lpddr_ctrl_model.idle(u_lpddr_ctrl_model.US_CK);
    v = 8'h01;
    for (int i = 0; i < 20 && v[MR0_DAI] !== 1'b0; i++) mrr(MA_MR0);
    chk(32'(v[MR0_DAI]), 32'h0);
    chk(32'($time - t0 <= 10000), 32'h1);
    rdchk(A_STATUS, 32'(ST_IDLE));
  endtask : wait_dai
  task automatic wr_rd(input logic [3:0] wa, input logic [63:0] w);
    rd_q.delete();
    u_lpddr_ctrl_model.cmd({6'($random(seed)), 4'h4}, {4'($random(seed)), wa, 2'($random(seed))}, w);
    u_lpddr_ctrl_model.cmd({6'($random(seed)), 4'h5}, {4'($random(seed)), wa, 2'($random(seed))}, '1);
    u_lpddr_ctrl_model.idle(2);
    chk(32'(rd_q.size()), 32'h4);
    chk({rd_q[1], rd_q[0]}, w[31:0]);
    chk({rd_q[3], rd_q[2]}, w[63:32]);
  endtask : wr_rd
  initial begin
    logic [7:0]  ainit;
    logic [23:0] mrs;
    logic [63:0] w;
    logic        rzq;
    time         t0;
    seed = 32'h2ef9;
    err_count = 0;
    tests_run = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 5; i++) rdchk(RA[i], RV[i]);
    apb(1'b1, 8'h14 + 8'({4'($random(seed)), 2'b00}), 32'hffff_ffff);
    chk(32'(e), 32'h1);
    rdchk(8'h14 + 8'({4'($random(seed)), 2'b00}), 32'h0);
    chk(32'(e), 32'h1);
    apb(1'b1, A_MR0, 32'hff);
    rdchk(A_MR0, 32'h1);
    apb(1'b1, A_AINIT, 32'hff);
    rdchk(A_AINIT, exp_ainit(32'hff));
    ainit = 8'h40 + 8'(6'($random(seed)));
    apb(1'b1, A_AINIT, 32'(ainit));
    rdchk(A_AINIT, exp_ainit(32'(ainit)));
    u_lpddr_ctrl_model.power_up();
    u_lpddr_ctrl_model.idle(u_lpddr_ctrl_model.NOP_CK);
    rdchk(A_STATUS, 32'(ST_NOP_IDLE));
    t0 = $time;
    u_lpddr_ctrl_model.mrw(MA_RESET, 8'h00);
    rdchk(A_STATUS, 32'(ST_AUTO_INIT));
    rdchk(A_MR0, 32'h1);
    wait_dai(t0);
    mrr(MA_MR8);
    chk(32'(v), 32'(MR8_VALUE));
    rzq = 1'($random(seed));
    apb(1'b1, A_CTRL, 32'(rzq));
    u_lpddr_ctrl_model.mrw(MA_ZQ, OP_ZQ_INIT);
    u_lpddr_ctrl_model.idle(u_lpddr_ctrl_model.US_CK);
    mrr(MA_MR0);
    chk(32'(v[MR0_RZQ_L +: 2]), 32'(rzq ? RZQ_OK : RZQ_OPEN));
    for (int i = 1; i < 4; i++) begin
      mrs[8*(i-1) +: 8] = 8'($random(seed));
      u_lpddr_ctrl_model.mrw(8'(i), mrs[8*(i-1) +: 8]);
    end
    rdchk(A_MRCFG, {8'h00, mrs});
    for (int k = 0; k < 3; k++) begin
      for (int b = 0; b < 4; b++) w[16*b +: 16] = {12'($random(seed)), 4'(b)};
      wr_rd(4'($random(seed)), w);
    end
    t0 = $time;
    u_lpddr_ctrl_model.mrw(MA_RESET, 8'h00);
    rdchk(A_MR0, 32'h1);
    wait_dai(t0);
    u_lpddr_ctrl_model.hp = 100;
    u_lpddr_ctrl_model.idle(3);
    u_lpddr_ctrl_model.hp = 160;
    u_lpddr_ctrl_model.idle(4);
    rdchk(A_STATUS, 32'(ST_IDLE) | (32'h1 << ST_FERR));
    apb(1'b1, A_STATUS, 32'h1 << ST_FERR);
    rdchk(A_STATUS, 32'(ST_IDLE));
    results();
  end
endmodule : lpddr_init_sequence_tb
`default_nettype wire
